//--- osc_model.sv
// oscillator model: one rising edge every eight system cycles while enabled
`timescale 1ns/1ps
module osc_model (
   input wire sys_clk, // system clock
   input wire rst, // reset
   input wire en, // oscillation on
   output logic osc_in, // oscillator waveform
   output logic xtal_det_in // amplitude detector
);
   logic [2:0] ph_r;
   // stopped oscillator rests low, which the missing-clock path must catch
   always @(posedge sys_clk or posedge rst) begin
      if (rst) ph_r <= 3'h0;
      else ph_r <= en ? ph_r + 3'h1 : 3'h0;
   end
   assign osc_in = ph_r[2];
   assign xtal_det_in = en;
endmodule // osc_model

//--- rtc_core_checker.sv
// port checker for the real-time clock core
`timescale 1ns/1ps
module rtc_core_checker #(
   parameter MCLK_CYCLES = 20
) (
   input wire sys_clk, // clock
   input wire rst, // reset
   input wire [3:0] addr, // offset
   input wire [7:0] wdata, // write data
   input wire wr, // write strobe
   input wire rd, // read strobe
   input wire [7:0] rdata, // read data
   input wire osc_in, // oscillator
   input wire xtal_det_in, // detector
   input wire osc_power_en, // power
   input wire xtal_mode_sel, // crystal mode
   input wire auto_gain_en, // gain control
   input wire bias_double, // bias
   input wire [3:0] cap_applied, // load cap
   input wire alarm_event, // alarm pulse
   input wire osc_fail_event // fail pulse
);
   logic osc_q_r;
   logic [15:0] stuck_r;
   // saturating count of cycles with the oscillator level unchanged
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_q_r <= 1'b0;
         stuck_r <= 16'h0000;
      end else begin
         osc_q_r <= osc_in;
         if (osc_in != osc_q_r)
            stuck_r <= 16'h0000;
         else if (stuck_r != 16'hFFFF)
            stuck_r <= stuck_r + 16'h0001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence osc_wr_s; wr && addr == 4'h5; endsequence
   sequence ctl_wr_s; wr && addr == 4'h4; endsequence
   a_alarm_one_cycle: assert property (alarm_event |=> !alarm_event)
      else $error("alarm pulse longer than one cycle");
   a_fail_one_cycle: assert property (osc_fail_event |=> !osc_fail_event)
      else $error("fail pulse longer than one cycle");
   a_fail_needs_stuck: assert property (osc_fail_event |->
      stuck_r >= MCLK_CYCLES - 3) else $error("fail without stuck clock");
   a_alarm_on_tick: assert property (alarm_event |-> $past(osc_in) &&
      !$past(osc_in, 2)) else $error("alarm away from an oscillator edge");
   a_osc_bits_write: assert property (osc_wr_s |=>
      {xtal_mode_sel, auto_gain_en, bias_double} == $past(wdata[7:5]))
      else $error("oscillator control outputs wrong");
   a_power_write: assert property (ctl_wr_s |=>
      osc_power_en == $past(wdata[7])) else $error("power output wrong");
   a_cap_unit_step: assert property (cap_applied > $past(cap_applied) &&
      !$past(wr) && !$past(wr, 2) |-> cap_applied == $past(cap_applied) + 4'h1)
      else $error("load cap jumped upward");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule // rtc_core_checker
bind rtc_timer_alarm_osc_ctrl rtc_core_checker #(.MCLK_CYCLES(MCLK_CYCLES))
   chk_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .osc_in(osc_in), .xtal_det_in(xtal_det_in),
   .osc_power_en(osc_power_en), .xtal_mode_sel(xtal_mode_sel),
   .auto_gain_en(auto_gain_en), .bias_double(bias_double),
   .cap_applied(cap_applied), .alarm_event(alarm_event),
   .osc_fail_event(osc_fail_event));

//--- rtc_timer_alarm_osc_ctrl.v
// real-time clock core: timer, alarm, missing-clock and crystal control
`timescale 1ns/1ps
`include "rtc_timer_consts.vh"

// Function
// - 32-bit timer counts each oscillator cycle while run is set, else holds
// - timer and alarm advance only on the oscillator timebase
// - load request copies snapshot bytes into timer, then clears itself
// - snapshot request copies timer into snapshot bytes, then clears itself
// - load and snapshot work while the timer keeps running
// - alarm fires on exact equality of timer and alarm match value
// - with auto reset, timer clears one oscillator cycle after alarm
// - alarm flag position writes auto reset enable, reads alarm flag
// - alarm event offered for interrupt or wake-up
// - oscillator stuck high or low over 100 us sets fail flag
// - missing-clock timeout offered for interrupt or wake-up
// - crystal-valid reads invalid for 2 ms after oscillator turn-on
// - crystal-valid detector readable as status in oscillator control
// - load capacitance selector is a 4-bit field of 16 settings
// - auto stepping starts at smallest setting on oscillator turn-on and steps up to final
// - ready flag set once applied setting equals programmed final
// - bias doubling control bit drives bias doubling
// - writing 0 to alarm enable clears the alarm flag
// - alarm flag stands at most one oscillator cycle; event pulses out
module rtc_timer_alarm_osc_ctrl #(
   parameter MCLK_CYCLES = `MCLK_TIMEOUT_NS / `CLK_PERIOD_NS,
   parameter BLANK_CYCLES = `XVLD_BLANK_NS / `CLK_PERIOD_NS,
   parameter STEP_CYCLES = `LCAP_STEP_NS / `CLK_PERIOD_NS
) (
   input wire sys_clk, // 200 MHz clock
   input wire rst, // async reset, high
   input wire [3:0] addr, // register offset
   input wire [7:0] wdata, // write data
   input wire wr, // write strobe
   input wire rd, // read strobe
   output reg [7:0] rdata, // read data, cycle after rd
   input wire osc_in, // oscillator output waveform
   input wire xtal_det_in, // amplitude detector output
   output reg osc_power_en, // oscillator power
   output reg xtal_mode_sel, // crystal mode select
   output reg auto_gain_en, // automatic gain control
   output reg bias_double, // bias doubling
   output reg [3:0] cap_applied, // load capacitance applied
   output reg alarm_event, // one-cycle alarm pulse
   output reg osc_fail_event // one-cycle missing-clock pulse
);

   reg [31:0] timer_r;
   reg [31:0] snap_r;
   reg [31:0] alarm_r;
   reg missing_clk_det_en;
   reg osc_fail_flag;
   reg timer_run;
   reg alarm_enable;
   reg alarm_flag;
   reg auto_reset;
   reg timer_load_req;
   reg timer_snapshot_req;
   reg auto_step_en;
   reg [3:0] sel_a;
   reg osc_prev_r;
   reg [19:0] mclk_cnt_r;
   reg [19:0] blank_cnt_r;
   reg [19:0] step_cnt_r;
   reg pwr_prev_r;
   reg [31:0] timer_nxt;

   wire wr_ctrl = wr && (addr == `RA_CTRL);
   wire osc_tick = osc_in && !osc_prev_r;
   wire pwr_rise = osc_power_en && !pwr_prev_r;
   wire blank_done = (blank_cnt_r == `CNT_ZERO);
   wire xtal_valid = osc_power_en && blank_done && xtal_det_in;
   wire sel_a_ready = (cap_applied == sel_a);
   wire step_due = (step_cnt_r == `CNT_ZERO);
   wire alarm_hit = alarm_enable && (timer_nxt != timer_r) &&
      (timer_nxt == alarm_r);

   // counters are 20 bits wide: counts must stay below 2^20, which the
   // 200 MHz defaults do with room to spare
   localparam [19:0] MCLK_LIM = MCLK_CYCLES[19:0];
   localparam [19:0] BLANK_LIM = BLANK_CYCLES[19:0];
   localparam [19:0] STEP_LIM = STEP_CYCLES[19:0];

   // word with one byte lane replaced, for software writes to a bank
   function [31:0] put_byte;
      input [31:0] w;
      input [1:0] idx;
      input [7:0] b;
      begin
         put_byte = w;
         put_byte[idx*8 +: 8] = b;
      end
   endfunction

   // true when the offset falls in the given four-byte bank
   function bank_hit;
      input [3:0] a;
      input [1:0] bank;
      begin
         bank_hit = (a[3:2] == bank);
      end
   endfunction

   // byte lane of a 32-bit word for offsets 0..3 of a bank
   function [7:0] byte_of;
      input [31:0] w;
      input [1:0] idx;
      begin
         byte_of = w[idx*8 +: 8];
      end
   endfunction

   // next timer value on a tick; load wins over counting
   always @* begin
      timer_nxt = timer_r;
      if (timer_load_req) begin
         timer_nxt = snap_r;
      end else if (timer_run) begin
         if (auto_reset && alarm_flag) begin
            timer_nxt = `TIMER_ZERO;
         end else begin
            timer_nxt = timer_r + `TIMER_ONE;
         end
      end
   end

   // timer, snapshot, alarm (all advance on the oscillator tick)
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_r <= `TIMER_ZERO;
         snap_r <= `TIMER_ZERO;
         alarm_r <= `TIMER_ZERO;
         alarm_flag <= 1'b0;
         alarm_event <= 1'b0;
         timer_load_req <= 1'b0;
         timer_snapshot_req <= 1'b0;
      end else begin
         alarm_event <= 1'b0;
         // software write to snapshot bytes; hardware capture below wins
         if (wr && bank_hit(addr, `BANK_SNAP)) begin
            snap_r <= put_byte(snap_r, addr[1:0], wdata);
         end
         if (wr && bank_hit(addr, `BANK_ALM)) begin
            alarm_r <= put_byte(alarm_r, addr[1:0], wdata);
         end
         // requests: software sets, hardware clears; set wins
         if (wr_ctrl && wdata[`B_LOAD]) begin
            timer_load_req <= 1'b1;
         end else if (osc_tick && timer_load_req) begin
            timer_load_req <= 1'b0;
         end
         if (wr_ctrl && wdata[`B_SNAP]) begin
            timer_snapshot_req <= 1'b1;
         end else if (osc_tick && timer_snapshot_req) begin
            timer_snapshot_req <= 1'b0;
         end
         if (osc_tick) begin
            timer_r <= timer_nxt;
            // a held timer must not keep the flag up past one cycle
            alarm_flag <= alarm_hit;
            if (alarm_hit) begin
               alarm_event <= 1'b1;
            end
            if (timer_snapshot_req) begin
               snap_r <= timer_r;
            end
         end
         if (wr_ctrl && !wdata[`B_AEN]) begin
            alarm_flag <= 1'b0;
         end
      end
   end

   // control and oscillator settings
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_power_en <= 1'b0;
         missing_clk_det_en <= 1'b0;
         timer_run <= 1'b0;
         alarm_enable <= 1'b0;
         auto_reset <= 1'b0;
         xtal_mode_sel <= 1'b0;
         auto_gain_en <= 1'b0;
         bias_double <= 1'b0;
         auto_step_en <= 1'b0;
         sel_a <= `LCAP_MIN;
      end else if (wr) begin
         case (addr)
            `RA_CTRL: begin
               osc_power_en <= wdata[`B_PWR];
               missing_clk_det_en <= wdata[`B_MCLK];
               timer_run <= wdata[`B_RUN];
               alarm_enable <= wdata[`B_AEN];
               auto_reset <= wdata[`B_ALARM_FLAG_AUTORESET];
            end
            `RA_OSC: begin
               xtal_mode_sel <= wdata[`B_XTAL_MODE_SEL];
               auto_gain_en <= wdata[`B_AGC];
               bias_double <= wdata[`B_BIAS];
            end
            `RA_LCAP: begin
               auto_step_en <= wdata[`B_STEP];
               sel_a <= wdata[`LCAP_MSB:0];
            end
            default: begin
            end
         endcase
      end
   end

   // missing-clock detector: one-shot, counts cycles since last osc edge
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_prev_r <= 1'b0;
         mclk_cnt_r <= `CNT_ZERO;
         osc_fail_flag <= 1'b0;
         osc_fail_event <= 1'b0;
      end else begin
         osc_prev_r <= osc_in;
         osc_fail_event <= 1'b0;
         if (!missing_clk_det_en || (osc_in != osc_prev_r)) begin
            mclk_cnt_r <= `CNT_ZERO;
         end else if (mclk_cnt_r < MCLK_LIM) begin
            mclk_cnt_r <= mclk_cnt_r + `CNT_ONE;
         end
         // fires once when the count first reaches the limit
         if (missing_clk_det_en && (osc_in == osc_prev_r) &&
             (mclk_cnt_r == MCLK_LIM - `CNT_ONE)) begin
            osc_fail_flag <= 1'b1;
            osc_fail_event <= 1'b1;
         end else if (wr_ctrl && !wdata[`B_FAIL]) begin
            osc_fail_flag <= 1'b0;
         end
      end
   end

   // crystal-valid blanking and load capacitance stepping
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwr_prev_r <= 1'b0;
         blank_cnt_r <= `CNT_ZERO;
         step_cnt_r <= `CNT_ZERO;
         cap_applied <= `LCAP_MIN;
      end else begin
         pwr_prev_r <= osc_power_en;
         if (pwr_rise) begin
            blank_cnt_r <= BLANK_LIM;
         end else if (!blank_done) begin
            blank_cnt_r <= blank_cnt_r - `CNT_ONE;
         end
         if (!auto_step_en) begin
            cap_applied <= sel_a;
            step_cnt_r <= `CNT_ZERO;
         end else if (pwr_rise) begin
            cap_applied <= `LCAP_MIN;
            step_cnt_r <= STEP_LIM;
         end else if (cap_applied > sel_a) begin
            cap_applied <= sel_a;
         end else if (cap_applied < sel_a) begin
            // slow stepping gives the crystal a fast, light start
            if (step_due) begin
               cap_applied <= cap_applied + 4'h1;
               step_cnt_r <= STEP_LIM;
            end else begin
               step_cnt_r <= step_cnt_r - `CNT_ONE;
            end
         end
      end
   end

   // read port: data stand one cycle after the strobe
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata <= `BYTE_ZERO;
      end else if (rd) begin
         case (addr)
            `RA_SNAP0, `RA_SNAP1, `RA_SNAP2, `RA_SNAP3:
               rdata <= byte_of(snap_r, addr[1:0]);
            `RA_ALM0, `RA_ALM1, `RA_ALM2, `RA_ALM3:
               rdata <= byte_of(alarm_r, addr[1:0]);
            `RA_CTRL:
               rdata <= {osc_power_en, missing_clk_det_en, osc_fail_flag,
                         timer_run, alarm_enable, alarm_flag,
                         timer_load_req, timer_snapshot_req};
            `RA_OSC:
               rdata <= {xtal_mode_sel, auto_gain_en, bias_double,
                         xtal_valid, 4'h0};
            `RA_LCAP:
               rdata <= {sel_a_ready, auto_step_en, 2'b00, sel_a};
            default:
               rdata <= `BYTE_ZERO;
         endcase
      end else begin
         rdata <= `BYTE_ZERO;
      end
   end

endmodule // rtc_timer_alarm_osc_ctrl

//--- rtc_timer_alarm_osc_ctrl_tb_top.sv
// testbench for the real-time clock core
`timescale 1ns/1ps
module rtc_timer_alarm_osc_ctrl_tb_top;
   logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, osc_en = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, d;
   wire [7:0] rdata;
   wire [3:0] cap;
   wire osc_in, xdet, pwr, xm, agc, bias, ae, fe;
   int error_cnt = 0, num_checks = 0, cyc = 0, alarms = 0, a0;
   initial forever #2.5 sys_clk = ~sys_clk;
   rtc_timer_alarm_osc_ctrl #(.MCLK_CYCLES(20), .BLANK_CYCLES(30),
      .STEP_CYCLES(5)) dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_in(osc_in),
      .xtal_det_in(xdet), .osc_power_en(pwr), .xtal_mode_sel(xm),
      .auto_gain_en(agc), .bias_double(bias), .cap_applied(cap),
      .alarm_event(ae), .osc_fail_event(fe));
   osc_model osc_u (.sys_clk(sys_clk), .rst(rst), .en(osc_en),
      .osc_in(osc_in), .xtal_det_in(xdet));
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (ae === 1'b1) alarms <= alarms + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         test_done;
      end
   end
   task wr_reg(input [3:0] a, input [7:0] v);
      @(posedge sys_clk);
      wr <= 1'b1; addr <= a; wdata <= v;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task chk(input string n, input [7:0] e, input [7:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task chk_rd(input [3:0] a, input [7:0] e);
      @(posedge sys_clk);
      rd <= 1'b1; addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
      chk("rdata", e, d);
   endtask
   // each run of 8 cycles gives exactly one oscillator rising edge
   task osc_run(input int n);
      osc_en <= 1'b1;
      repeat (n) @(posedge sys_clk);
      osc_en <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      chk_rd(4'h4, 8'h00);
      chk_rd(4'h7, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) wr_reg(i[3:0], 8'hFF);
      wr_reg(4'h4, 8'h02);
      osc_run(12);
      chk_rd(4'h4, 8'h00);
      wr_reg(4'h4, 8'h10);
      osc_run(24);
      wr_reg(4'h4, 8'h01);
      osc_run(8);
      for (int i = 0; i < 4; i++) chk_rd(i[3:0], i == 0 ? 8'h02 : 8'h00);
      chk_rd(4'h4, 8'h00);
      $display("test load and snapshot done");
      for (int i = 0; i < 4; i++) wr_reg(i[3:0], 8'h00);
      wr_reg(4'h4, 8'h12);
      osc_run(8);
      for (int i = 0; i < 4; i++) wr_reg(4'h8 + i[3:0], i == 0 ? 8'h03 : 8'h00);
      wr_reg(4'h4, 8'h1C);
      a0 = alarms;
      osc_run(80);
      chk("alarm_count", 8'h02, 8'(alarms - a0));
      osc_run(8);
      chk_rd(4'h4, 8'h1C);
      wr_reg(4'h4, 8'h10);
      chk_rd(4'h4, 8'h10);
      $display("test alarm auto reset done");
      wr_reg(4'h4, 8'h40);
      repeat (40) @(posedge sys_clk);
      chk_rd(4'h4, 8'h60);
      wr_reg(4'h4, 8'h40);
      repeat (40) @(posedge sys_clk);
      chk_rd(4'h4, 8'h40);
      $display("test missing clock done");
      wr_reg(4'h4, 8'h00);
      wr_reg(4'h5, 8'hA0);
      #1 chk("osc_out", 8'h05, {5'h00, xm, agc, bias});
      chk_rd(4'h5, 8'hA0);
      osc_en <= 1'b1;
      wr_reg(4'h6, 8'h45);
      wr_reg(4'h4, 8'h80);
      chk_rd(4'h6, 8'h45);
      chk_rd(4'h5, 8'hA0);
      repeat (60) @(posedge sys_clk);
      chk_rd(4'h6, 8'hC5);
      chk("cap", 8'h05, {4'h0, cap});
      chk_rd(4'h5, 8'hB0);
      $display("test load cap and blanking done");
      wr_reg(4'h4, 8'hC0);
      repeat (40) @(posedge sys_clk);
      chk_rd(4'h4, 8'hC0);
      wr_reg(4'h4, 8'h80);
      wr_reg(4'h5, 8'h20);
      #1 chk("osc_self", 8'h01, {5'h00, xm, agc, bias});
      chk_rd(4'h5, 8'h30);
      osc_en <= 1'b0;
      wr_reg(4'h4, 8'hC0);
      repeat (40) @(posedge sys_clk);
      chk_rd(4'h4, 8'hE0);
      $display("test oscillator modes done");
      test_done;
   end
endmodule // rtc_timer_alarm_osc_ctrl_tb_top

//--- rtc_timer_consts.vh
// constants for the real-time clock timer, alarm and oscillator control
`ifndef RTC_TIMER_CONSTS_VH
`define RTC_TIMER_CONSTS_VH

// register offsets
`define RA_SNAP0 4'h0
`define RA_SNAP1 4'h1
`define RA_SNAP2 4'h2
`define RA_SNAP3 4'h3
`define RA_CTRL 4'h4
`define RA_OSC 4'h5
`define RA_LCAP 4'h6
`define RA_ALM0 4'h8
`define RA_ALM1 4'h9
`define RA_ALM2 4'hA
`define RA_ALM3 4'hB
`define BANK_SNAP 2'h0
`define BANK_ALM 2'h2

// rtc_control bits
`define B_PWR 7
`define B_MCLK 6
`define B_FAIL 5
`define B_RUN 4
`define B_AEN 3
`define B_ALARM_FLAG_AUTORESET 2
`define B_LOAD 1
`define B_SNAP 0

// osc_control bits
`define B_XTAL_MODE_SEL 7
`define B_AGC 6
`define B_BIAS 5
`define B_XVLD 4

// sel_a_config bits
`define B_LRDY 7
`define B_STEP 6
`define LCAP_MSB 3

`define LCAP_MIN 4'h0
`define TIMER_ZERO 32'h0000_0000
`define TIMER_ONE 32'h0000_0001
`define BYTE_ZERO 8'h00
`define CNT_ZERO 20'h00000
`define CNT_ONE 20'h00001

// times and clock period
`define CLK_PERIOD_NS 5
`define MCLK_TIMEOUT_NS 100000
`define XVLD_BLANK_NS 2000000
`define LCAP_STEP_NS 50000

`endif
